// ==== hw/fsa_pkg.sv ====
// constants and types shared by the four-port switch array design
// assumes one 100 MHz system clock; port clocks arrive as enable pulses
package fsa_pkg;

    // =====================================================
    // array shape
    localparam int NUM_PORTS = 4;
    localparam int ADDR_W = 16;
    localparam int DATA_W = 18;
    localparam int BYTE_W = 9;
    localparam int BYTES = 2;
    localparam int UB_IDX = 1;
    localparam int LB_IDX = 0;
    localparam int TGT_W = 2;

    // =====================================================
    // timing
    localparam int CLK_PERIOD_NS = 10;
    localparam int WR_PULSE_NS = 20;
    // least time, so round up, never below one cycle
    localparam int WR_PULSE_RAW = (WR_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int WR_PULSE_CYC = (WR_PULSE_RAW < 1) ? 1 : WR_PULSE_RAW;
    localparam int WP_CNT_W = 8;

    // =====================================================
    // reset values
    localparam logic [ADDR_W-1:0] CNT_RESET = 16'h0000;
    localparam logic [ADDR_W-1:0] MASK_RESET = 16'hffff;
    localparam logic [DATA_W-1:0] DATA_RESET = 18'h00000;

    // =====================================================
    // write pulse states
    typedef enum logic [0:0] {
        WP_IDLE = 1'b0,
        WP_ACTIVE = 1'b1
    } fsa_wp_state_t;

endpackage

// ==== hw/fsa_wr_pulse.sv ====
// self-timed write strobe generator for one port
// assumes start is a one-cycle pulse in the sys_clk domain
module fsa_wr_pulse #(
    parameter int WIDTH = fsa_pkg::WR_PULSE_CYC
) (
    // clock and resets
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire logic master_reset_n,
    // request and strobe
    input wire logic start,
    output logic pulse
);

    fsa_pkg::fsa_wp_state_t state_q;
    logic [fsa_pkg::WP_CNT_W-1:0] left_q;

    // =====================================================
    // pulse timer: high for WIDTH cycles after the last start, so a start standing while high extends it
    always_ff @(posedge sys_clk or negedge master_reset_n) begin
        if (!master_reset_n) begin
            state_q <= fsa_pkg::WP_IDLE;
            left_q <= '0;
        end else if (!reset_n) begin
            state_q <= fsa_pkg::WP_IDLE;
            left_q <= '0;
        end else begin
            case (state_q)
                fsa_pkg::WP_IDLE: begin
                    if (start) begin
                        state_q <= fsa_pkg::WP_ACTIVE;
                        left_q <= fsa_pkg::WP_CNT_W'(WIDTH - 1);
                    end
                end
                fsa_pkg::WP_ACTIVE: begin
                    if (start) begin
                        left_q <= fsa_pkg::WP_CNT_W'(WIDTH - 1); // new write restarts
                    end else if (left_q == '0) begin
                        state_q <= fsa_pkg::WP_IDLE;
                    end else begin
                        left_q <= left_q - 1'b1;
                    end
                end
                default: begin
                    state_q <= fsa_pkg::WP_IDLE;
                end
            endcase
        end
    end

    assign pulse = (state_q == fsa_pkg::WP_ACTIVE);

endmodule

// ==== hw/fsa_mem.sv ====
// shared storage array with one read and one write path per port
// assumes callers never write one word from two ports in one cycle
module fsa_mem #(
    parameter int PORTS = fsa_pkg::NUM_PORTS,
    parameter int AW = fsa_pkg::ADDR_W,
    parameter int DW = fsa_pkg::DATA_W
) (
    // clock
    input wire logic sys_clk,
    // read paths
    input wire logic [PORTS-1:0] rd_en,
    input wire logic [PORTS-1:0][AW-1:0] rd_addr,
    output logic [PORTS-1:0][DW-1:0] rd_data,
    // write paths
    input wire logic [PORTS-1:0] wr_en,
    input wire logic [PORTS-1:0][fsa_pkg::BYTES-1:0] wr_be,
    input wire logic [PORTS-1:0][AW-1:0] wr_addr,
    input wire logic [PORTS-1:0][DW-1:0] wr_data
);

    localparam int DEPTH = 1 << AW;
    localparam int BW = fsa_pkg::BYTE_W;

    logic [DW-1:0] mem [DEPTH];

    // =====================================================
    // writes: byte halves apart; same-word clashes favour the higher port
    always_ff @(posedge sys_clk) begin
        for (int p = 0; p < PORTS; p++) begin
            for (int b = 0; b < fsa_pkg::BYTES; b++) begin
                if (wr_en[p] && wr_be[p][b]) begin
                    mem[wr_addr[p]][b*BW +: BW] <= wr_data[p][b*BW +: BW];
                end
            end
        end
    end

    // =====================================================
    // reads: every port reaches every word, result held in a register
    for (genvar p = 0; p < PORTS; p++) begin : g_rd
        always_ff @(posedge sys_clk) begin
            if (rd_en[p]) begin
                rd_data[p] <= mem[rd_addr[p]];
            end
        end
    end

endmodule

// ==== hw/fsa_top.sv ====
// per-port control of a four-port pipelined switch array, 64K x 18
// assumes each port clock edge arrives as a one-cycle sys_clk enable
module fsa_top #(
    parameter int NUM_PORTS = fsa_pkg::NUM_PORTS,
    parameter int WR_PULSE_CYC = fsa_pkg::WR_PULSE_CYC
) (
    // clock and resets
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire logic master_reset_n,

    // port clock edges
    input wire logic [NUM_PORTS-1:0] port_clk_en,

    // access controls
    input wire logic [NUM_PORTS-1:0] chip_select_low_active,
    input wire logic [NUM_PORTS-1:0] chip_select_high_active,
    input wire logic [NUM_PORTS-1:0] read_not_write,
    input wire logic [NUM_PORTS-1:0] output_enable_n,
    input wire logic [NUM_PORTS-1:0] upper_byte_sel_n,
    input wire logic [NUM_PORTS-1:0] lower_byte_sel_n,

    // address lines
    input wire logic [NUM_PORTS-1:0][fsa_pkg::ADDR_W-1:0] addr_in,
    output logic [NUM_PORTS-1:0][fsa_pkg::ADDR_W-1:0] addr_out,
    output logic [NUM_PORTS-1:0] addr_oe,

    // data lines, one enable per byte half
    input wire logic [NUM_PORTS-1:0][fsa_pkg::DATA_W-1:0] data_in,
    output logic [NUM_PORTS-1:0][fsa_pkg::DATA_W-1:0] data_out,
    output logic [NUM_PORTS-1:0][fsa_pkg::BYTES-1:0] data_oe,

    // burst counter and mask controls
    input wire logic [NUM_PORTS-1:0] burst_counter_load_n,
    input wire logic [NUM_PORTS-1:0] burst_counter_advance,
    input wire logic [NUM_PORTS-1:0] burst_counter_clear,
    input wire logic [NUM_PORTS-1:0] mask_load_n,
    input wire logic [NUM_PORTS-1:0] wrap_mask_readback,
    input wire logic [NUM_PORTS-1:0] burst_counter_readback,

    // message passing
    input wire logic [NUM_PORTS-1:0] msg_raise,
    input wire logic [NUM_PORTS-1:0][fsa_pkg::TGT_W-1:0] msg_target,
    input wire logic [NUM_PORTS-1:0] msg_clear,

    // status
    output logic [NUM_PORTS-1:0] counter_wrap_flag,
    output logic [NUM_PORTS-1:0] msg_flag,
    output logic [NUM_PORTS-1:0] power_down
);

    localparam int AW = fsa_pkg::ADDR_W;
    localparam int DW = fsa_pkg::DATA_W;
    localparam int NB = fsa_pkg::BYTES;

    // =====================================================
    // helpers

    // both chip selects in their asserted states
    function automatic logic fsa_selected(input logic cs_low, input logic cs_high);
        fsa_selected = ~cs_low & cs_high;
    endfunction

    // active-low byte selects to a byte enable vector
    function automatic logic [NB-1:0] fsa_bytes(input logic ub_n, input logic lb_n);
        logic [NB-1:0] be;
        be = '0;
        be[fsa_pkg::UB_IDX] = ~ub_n;
        be[fsa_pkg::LB_IDX] = ~lb_n;
        fsa_bytes = be;
    endfunction

    // =====================================================
    // per-port signals

    logic [NUM_PORTS-1:0] sel;
    logic [NUM_PORTS-1:0] edge_sel;
    logic [NUM_PORTS-1:0] rd_go;
    logic [NUM_PORTS-1:0] wr_go;
    logic [NUM_PORTS-1:0] wrap;
    logic [NUM_PORTS-1:0] wr_strobe;
    logic [NUM_PORTS-1:0] msg_set;
    logic [NUM_PORTS-1:0][AW-1:0] cnt_plus;
    logic [NUM_PORTS-1:0][AW-1:0] cnt_step;
    logic [NUM_PORTS-1:0][AW-1:0] cnt_d;
    logic [NUM_PORTS-1:0][DW-1:0] rd_data;

    logic [NUM_PORTS-1:0][AW-1:0] cnt_q;
    logic [NUM_PORTS-1:0][AW-1:0] mask_q;
    logic [NUM_PORTS-1:0] pd_q;
    logic [NUM_PORTS-1:0] wrap_flag_q;
    logic [NUM_PORTS-1:0] msg_q;
    logic [NUM_PORTS-1:0] rd_pend_q;
    logic [NUM_PORTS-1:0] out_valid_q;
    logic [NUM_PORTS-1:0][NB-1:0] rd_be_q;
    logic [NUM_PORTS-1:0][NB-1:0] out_be_q;
    logic [NUM_PORTS-1:0][DW-1:0] out_data_q;
    logic [NUM_PORTS-1:0][AW-1:0] wr_addr_q;
    logic [NUM_PORTS-1:0][DW-1:0] wr_data_q;
    logic [NUM_PORTS-1:0][NB-1:0] wr_be_q;
    logic [NUM_PORTS-1:0][AW-1:0] rb_addr_q;
    logic [NUM_PORTS-1:0] rb_oe_q;

    // =====================================================
    // message flag sets: any selected port edge aimed at this port
    always_comb begin
        msg_set = '0;
        for (int t = 0; t < NUM_PORTS; t++) begin
            for (int p = 0; p < NUM_PORTS; p++) begin
                if (edge_sel[p] && msg_raise[p] &&
                    msg_target[p] == fsa_pkg::TGT_W'(t)) begin
                    msg_set[t] = 1'b1;
                end
            end
        end
    end

    // =====================================================
    // one control slice per port
    for (genvar g = 0; g < NUM_PORTS; g++) begin : g_port

        // access decode on the port's own edge
        always_comb begin
            sel[g] = fsa_selected(chip_select_low_active[g], chip_select_high_active[g]);
            edge_sel[g] = port_clk_en[g] & sel[g];
            rd_go[g] = edge_sel[g] & read_not_write[g];
            wr_go[g] = edge_sel[g] & ~read_not_write[g];
        end

        // counter arithmetic: only masked bits move, the rest stay put
        always_comb begin
            cnt_plus[g] = cnt_q[g] + 16'h0001;
            cnt_step[g] = (cnt_q[g] & ~mask_q[g]) | (cnt_plus[g] & mask_q[g]);
            wrap[g] = &(cnt_q[g] | ~mask_q[g]);
        end

        // next counter value, used as the access address at this edge
        always_comb begin
            cnt_d[g] = cnt_q[g];
            if (burst_counter_clear[g]) begin
                cnt_d[g] = cnt_q[g] & ~mask_q[g];
            end else if (!burst_counter_load_n[g]) begin
                cnt_d[g] = addr_in[g];
            end else if (burst_counter_advance[g]) begin
                cnt_d[g] = cnt_step[g];
            end
        end

        // burst counter register, steps on port edges only
        always_ff @(posedge sys_clk or negedge master_reset_n) begin
            if (!master_reset_n) begin
                cnt_q[g] <= fsa_pkg::CNT_RESET;
            end else if (!reset_n) begin
                cnt_q[g] <= fsa_pkg::CNT_RESET;
            end else if (port_clk_en[g]) begin
                cnt_q[g] <= cnt_d[g];
            end
        end

        // wrap mask register, loaded from the address lines
        always_ff @(posedge sys_clk or negedge master_reset_n) begin
            if (!master_reset_n) begin
                mask_q[g] <= fsa_pkg::MASK_RESET;
            end else if (!reset_n) begin
                mask_q[g] <= fsa_pkg::MASK_RESET;
            end else if (port_clk_en[g] && !mask_load_n[g]) begin
                mask_q[g] <= addr_in[g];
            end
        end

        // wrap flag: set by an advance past the top, cleared by clear or load
        always_ff @(posedge sys_clk or negedge master_reset_n) begin
            if (!master_reset_n) begin
                wrap_flag_q[g] <= 1'b0;
            end else if (!reset_n) begin
                wrap_flag_q[g] <= 1'b0;
            end else if (port_clk_en[g]) begin
                if (burst_counter_clear[g] || !burst_counter_load_n[g]) begin
                    wrap_flag_q[g] <= 1'b0;
                end else if (burst_counter_advance[g] && wrap[g]) begin
                    wrap_flag_q[g] <= 1'b1;
                end
            end
        end

        // message flag: a set in the clearing cycle wins
        always_ff @(posedge sys_clk or negedge master_reset_n) begin
            if (!master_reset_n) begin
                msg_q[g] <= 1'b0;
            end else if (!reset_n) begin
                msg_q[g] <= 1'b0;
            end else if (msg_set[g]) begin
                msg_q[g] <= 1'b1;
            end else if (port_clk_en[g] && msg_clear[g]) begin
                msg_q[g] <= 1'b0;
            end
        end

        // power-down state follows the selects on each port edge
        always_ff @(posedge sys_clk or negedge master_reset_n) begin
            if (!master_reset_n) begin
                pd_q[g] <= 1'b1;
            end else if (!reset_n) begin
                pd_q[g] <= 1'b1;
            end else if (port_clk_en[g]) begin
                pd_q[g] <= ~sel[g];
            end
        end

        // read pipeline: array read at edge k, output register at edge k+1
        always_ff @(posedge sys_clk or negedge master_reset_n) begin
            if (!master_reset_n) begin
                rd_pend_q[g] <= 1'b0;
                rd_be_q[g] <= '0;
                out_valid_q[g] <= 1'b0;
                out_be_q[g] <= '0;
                out_data_q[g] <= fsa_pkg::DATA_RESET;
            end else if (!reset_n) begin
                rd_pend_q[g] <= 1'b0;
                rd_be_q[g] <= '0;
                out_valid_q[g] <= 1'b0;
                out_be_q[g] <= '0;
                out_data_q[g] <= fsa_pkg::DATA_RESET;
            end else if (port_clk_en[g]) begin
                rd_pend_q[g] <= rd_go[g];
                rd_be_q[g] <= fsa_bytes(upper_byte_sel_n[g], lower_byte_sel_n[g]);
                out_valid_q[g] <= rd_pend_q[g];
                out_be_q[g] <= rd_be_q[g];
                if (rd_pend_q[g]) begin
                    out_data_q[g] <= rd_data[g];
                end
            end
        end

        // write capture: address, data and halves held for the strobe
        always_ff @(posedge sys_clk or negedge master_reset_n) begin
            if (!master_reset_n) begin
                wr_addr_q[g] <= fsa_pkg::CNT_RESET;
                wr_data_q[g] <= fsa_pkg::DATA_RESET;
                wr_be_q[g] <= '0;
            end else if (!reset_n) begin
                wr_addr_q[g] <= fsa_pkg::CNT_RESET;
                wr_data_q[g] <= fsa_pkg::DATA_RESET;
                wr_be_q[g] <= '0;
            end else if (wr_go[g]) begin
                wr_addr_q[g] <= cnt_d[g];
                wr_data_q[g] <= data_in[g];
                wr_be_q[g] <= fsa_bytes(upper_byte_sel_n[g], lower_byte_sel_n[g]);
            end
        end

        // self-timed strobe started by the captured write
        fsa_wr_pulse #(
            .WIDTH(WR_PULSE_CYC)
        ) u_wr_pulse (
            .sys_clk(sys_clk),
            .reset_n(reset_n),
            .master_reset_n(master_reset_n),
            .start(wr_go[g]),
            .pulse(wr_strobe[g])
        );

        // address readback, mask first, independent of the selects
        always_ff @(posedge sys_clk or negedge master_reset_n) begin
            if (!master_reset_n) begin
                rb_addr_q[g] <= fsa_pkg::CNT_RESET;
                rb_oe_q[g] <= 1'b0;
            end else if (!reset_n) begin
                rb_addr_q[g] <= fsa_pkg::CNT_RESET;
                rb_oe_q[g] <= 1'b0;
            end else begin
                rb_oe_q[g] <= wrap_mask_readback[g] | burst_counter_readback[g];
                if (wrap_mask_readback[g]) begin
                    rb_addr_q[g] <= mask_q[g];
                end else begin
                    rb_addr_q[g] <= cnt_q[g];
                end
            end
        end

        // pin drive: data only when enabled, awake and holding a read
        always_comb begin
            addr_out[g] = rb_addr_q[g];
            addr_oe[g] = rb_oe_q[g];
            data_out[g] = out_data_q[g];
            data_oe[g] = '0;
            if (!output_enable_n[g] && !pd_q[g] && out_valid_q[g]) begin
                data_oe[g] = out_be_q[g];
            end
        end

    end

    // =====================================================
    // shared array

    fsa_mem #(
        .PORTS(NUM_PORTS),
        .AW(AW),
        .DW(DW)
    ) u_mem (
        .sys_clk(sys_clk),
        .rd_en(rd_go),
        .rd_addr(cnt_d),
        .rd_data(rd_data),
        .wr_en(wr_strobe),
        .wr_be(wr_be_q),
        .wr_addr(wr_addr_q),
        .wr_data(wr_data_q)
    );

    // =====================================================
    // status outputs
    assign counter_wrap_flag = wrap_flag_q;
    assign msg_flag = msg_q;
    assign power_down = pd_q;

endmodule

// ==== verification/fsa_props.sv ====
// =====================================================
// port-level checks for the four-port switch array control block
// assumes it is bound into fsa_top and sees only that module's ports
module fsa_props #(
    parameter int NUM_PORTS = 4
) (
    // clock and resets
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire logic master_reset_n,
    // port controls
    input wire logic [NUM_PORTS-1:0] port_clk_en,
    input wire logic [NUM_PORTS-1:0] chip_select_low_active,
    input wire logic [NUM_PORTS-1:0] chip_select_high_active,
    input wire logic [NUM_PORTS-1:0] burst_counter_load_n,
    input wire logic [NUM_PORTS-1:0] burst_counter_advance,
    input wire logic [NUM_PORTS-1:0] burst_counter_clear,
    input wire logic [NUM_PORTS-1:0] wrap_mask_readback,
    input wire logic [NUM_PORTS-1:0] burst_counter_readback,
    input wire logic [NUM_PORTS-1:0] msg_raise,
    input wire logic [NUM_PORTS-1:0][fsa_pkg::TGT_W-1:0] msg_target,
    // outputs
    input wire logic [NUM_PORTS-1:0][fsa_pkg::DATA_W-1:0] data_out,
    input wire logic [NUM_PORTS-1:0][fsa_pkg::BYTES-1:0] data_oe,
    input wire logic [NUM_PORTS-1:0] addr_oe,
    input wire logic [NUM_PORTS-1:0] counter_wrap_flag,
    input wire logic [NUM_PORTS-1:0] msg_flag,
    input wire logic [NUM_PORTS-1:0] power_down
);
    // fully selected port edge
    wire logic [NUM_PORTS-1:0] sel_edge = port_clk_en & ~chip_select_low_active &
        chip_select_high_active;
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!reset_n || !master_reset_n);
    // =====================================================
    // one set of checks per port
    for (genvar g = 0; g < NUM_PORTS; g++) begin : g_port
        property p_rb_drive;
            (wrap_mask_readback[g] || burst_counter_readback[g]) |=> addr_oe[g];
        endproperty
        a_rb_drive: assert property (p_rb_drive)
            else $error("readback not driven on address lines");
        property p_rb_release;
            !(wrap_mask_readback[g] || burst_counter_readback[g]) |=> !addr_oe[g];
        endproperty
        a_rb_release: assert property (p_rb_release)
            else $error("address lines driven without readback");
        property p_pd_enter;
            port_clk_en[g] && !sel_edge[g] |=> power_down[g];
        endproperty
        a_pd_enter: assert property (p_pd_enter)
            else $error("deselected edge did not power down");
        property p_pd_wake;
            $fell(power_down[g]) |-> $past(sel_edge[g]);
        endproperty
        a_pd_wake: assert property (p_pd_wake)
            else $error("port woke without a selected edge");
        property p_oe_pd;
            data_oe[g] != 2'h0 |-> !power_down[g];
        endproperty
        a_oe_pd: assert property (p_oe_pd)
            else $error("data driven while powered down");
        property p_out_hold;
            $past(reset_n) && $past(master_reset_n) && !$stable(data_out[g])
                |-> $past(port_clk_en[g]);
        endproperty
        a_out_hold: assert property (p_out_hold)
            else $error("read data changed between port edges");
        property p_wrap_cause;
            $rose(counter_wrap_flag[g]) |-> $past(port_clk_en[g]) &&
                $past(burst_counter_advance[g]);
        endproperty
        a_wrap_cause: assert property (p_wrap_cause)
            else $error("wrap flag rose without an advancing edge");
        property p_wrap_clear;
            port_clk_en[g] && (burst_counter_clear[g] || !burst_counter_load_n[g])
                |=> !counter_wrap_flag[g];
        endproperty
        a_wrap_clear: assert property (p_wrap_clear)
            else $error("wrap flag kept after clear or load");
        property p_msg_set;
            sel_edge[g] && msg_raise[g] |=> msg_flag[$past(msg_target[g])];
        endproperty
        a_msg_set: assert property (p_msg_set)
            else $error("message flag not raised at target");
    end
endmodule

bind fsa_top fsa_props #(.NUM_PORTS(NUM_PORTS)) i_props (.sys_clk, .reset_n, .master_reset_n,
    .port_clk_en, .chip_select_low_active, .chip_select_high_active, .burst_counter_load_n,
    .burst_counter_advance, .burst_counter_clear, .wrap_mask_readback, .burst_counter_readback,
    .msg_raise, .msg_target, .data_out, .data_oe, .addr_oe, .counter_wrap_flag, .msg_flag,
    .power_down);

// ==== verification/fsa_host.sv ====
// =====================================================
// host agent model: turns bench requests into port clock edges
// assumes requests are levels held until the edge has been issued
module fsa_host (
    // clock
    input wire logic sys_clk,
    // requests and port edges
    input wire logic [3:0] edge_req,
    output logic [3:0] port_clk_en
);
    timeunit 1ns;
    timeprecision 100ps;
    initial port_clk_en = 4'h0;
    // only the lowest requested port gets an edge, so no word is hit twice at once
    always @(posedge sys_clk) begin
        port_clk_en <= edge_req & (~edge_req + 4'h1);
    end
endmodule

// ==== verification/tb.sv ====
// =====================================================
// self-checking bench for the four-port switch array control block
// assumes the host model issues every port edge one cycle after a request
module tb;
    timeunit 1ns;
    timeprecision 100ps;
    logic sys_clk, reset_n, mrst_n;
    logic [3:0] req, pce, cs_n, cs, rnw, oe_n, ub_n, lb_n, ld_n, adv, clr, mld_n, mrd, crd, mr, mc;
    logic [3:0] aoe, wflag, mflag, pd;
    logic [3:0][1:0] mt, doe;
    logic [3:0][fsa_pkg::ADDR_W-1:0] addr, aout;
    logic [3:0][fsa_pkg::DATA_W-1:0] din, dout;
    int miscompares = 0;
    int n_tests = 0;
    int cycles = 0;
    fsa_host i_host (.sys_clk(sys_clk), .edge_req(req), .port_clk_en(pce));
    fsa_top #(.WR_PULSE_CYC(2)) i_dut (.sys_clk(sys_clk), .reset_n(reset_n),
        .master_reset_n(mrst_n), .port_clk_en(pce), .chip_select_low_active(cs_n),
        .chip_select_high_active(cs), .read_not_write(rnw), .output_enable_n(oe_n),
        .upper_byte_sel_n(ub_n), .lower_byte_sel_n(lb_n), .addr_in(addr), .addr_out(aout),
        .addr_oe(aoe), .data_in(din), .data_out(dout), .data_oe(doe),
        .burst_counter_load_n(ld_n), .burst_counter_advance(adv), .burst_counter_clear(clr),
        .mask_load_n(mld_n), .wrap_mask_readback(mrd), .burst_counter_readback(crd),
        .msg_raise(mr), .msg_target(mt), .msg_clear(mc), .counter_wrap_flag(wflag),
        .msg_flag(mflag), .power_down(pd));
    // =====================================================
    // clock and hang guard
    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 3000) begin
            miscompares++;
            end_sim();
        end
    end
    // =====================================================
    // access tasks
    task end_sim();
        $display("comparisons %0d, mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            miscompares++;
            $display("mismatch at %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask
    // one port edge, controls held until it has been sampled
    task tick(input int g);
        req[g] = 1'b1;
        @(posedge sys_clk);
        #1 req[g] = 1'b0;
        @(posedge sys_clk);
        #1;
    endtask
    task ld(input int g, input logic [15:0] a);
        ld_n[g] = 1'b0;
        addr[g] = a;
        tick(g);
        ld_n[g] = 1'b1;
    endtask
    // extra cycle lets the strobe finish before any other port reads the word
    task wr(input int g, input logic [15:0] a, input logic [17:0] d);
        din[g] = d;
        rnw[g] = 1'b0;
        ld(g, a);
        rnw[g] = 1'b1;
        @(posedge sys_clk);
        #1;
    endtask
    task rb(input int g, input logic m, input logic [15:0] exp);
        mrd[g] = m;
        crd[g] = !m;
        @(posedge sys_clk);
        #1 chk(32'(aoe[g]), 32'h1);
        chk(32'(aout[g]), 32'(exp));
        mrd[g] = 1'b0;
        crd[g] = 1'b0;
        repeat (2) @(posedge sys_clk);
        #1 chk(32'(aoe[g]), 32'h0);
    endtask
    // =====================================================
    // test sequence
    initial begin
        reset_n = 1'b0;
        mrst_n = 1'b1;
        {req, cs_n, oe_n, ub_n, lb_n, adv, clr, mrd, crd, mr, mc} = '0;
        {cs, rnw, ld_n, mld_n} = '1;
        mt = '0;
        addr = '0;
        din = '0;
        repeat (5) @(posedge sys_clk);
        #1 reset_n = 1'b1;
        chk(32'(pd), 32'hf);
        // burst read of words written from another port
        wr(0, 16'h0100, 18'h2a5a5);
        wr(0, 16'h0101, 18'h1c3c3);
        ld(1, 16'h0100);
        adv[1] = 1'b1;
        tick(1);
        chk(32'(dout[1]), 32'h2a5a5);
        adv[1] = 1'b0;
        tick(1);
        chk(32'(dout[1]), 32'h1c3c3);
        chk(32'(doe[1]), 32'h3);
        // upper half written alone, lower half read not driven
        lb_n[0] = 1'b1;
        wr(0, 16'h0101, 18'h15a5a);
        lb_n[0] = 1'b0;
        lb_n[1] = 1'b1;
        ld(1, 16'h0101);
        tick(1);
        chk(32'(doe[1]), 32'h2);
        lb_n[1] = 1'b0;
        repeat (2) tick(1);
        chk(32'(dout[1]), 32'h15bc3);
        // power down and wake
        cs[1] = 1'b0;
        tick(1);
        chk(32'(pd[1]), 32'h1);
        chk(32'(doe[1]), 32'h0);
        cs[1] = 1'b1;
        tick(1);
        chk(32'(doe[1]), 32'h0);
        tick(1);
        chk(32'(doe[1]), 32'h3);
        // output enable released: no half driven although a read stands
        oe_n[1] = 1'b1;
        @(posedge sys_clk);
        #1 chk(32'(doe[1]), 32'h0);
        oe_n[1] = 1'b0;
        // counter at the top of the array, port deselected
        cs[2] = 1'b0;
        ld(2, 16'hfffe);
        adv[2] = 1'b1;
        tick(2);
        rb(2, 1'b0, 16'hffff);
        chk(32'(wflag[2]), 32'h0);
        tick(2);
        chk(32'(wflag[2]), 32'h1);
        adv[2] = 1'b0;
        rb(2, 1'b0, 16'h0000);
        rb(2, 1'b1, 16'hffff);
        // partition by mask
        mld_n[3] = 1'b0;
        addr[3] = 16'h000f;
        tick(3);
        mld_n[3] = 1'b1;
        rb(3, 1'b1, 16'h000f);
        ld(3, 16'h123e);
        adv[3] = 1'b1;
        repeat (2) tick(3);
        rb(3, 1'b0, 16'h1230);
        chk(32'(wflag[3]), 32'h1);
        ld_n[3] = 1'b0;
        addr[3] = 16'h1237;
        clr[3] = 1'b1;
        tick(3);
        chk(32'(wflag[3]), 32'h0);
        rb(3, 1'b0, 16'h1230);
        clr[3] = 1'b0;
        addr[3] = 16'h1235;
        tick(3);
        ld_n[3] = 1'b1;
        adv[3] = 1'b0;
        rb(3, 1'b0, 16'h1235);
        clr[3] = 1'b1;
        tick(3);
        clr[3] = 1'b0;
        rb(3, 1'b0, 16'h1230);
        // messages between ports
        mr[0] = 1'b1;
        mt[0] = 2'h2;
        tick(0);
        mr[0] = 1'b0;
        chk(32'(mflag), 32'h4);
        mc[2] = 1'b1;
        tick(2);
        mc[2] = 1'b0;
        chk(32'(mflag), 32'h0);
        // master reset between clock edges
        @(posedge sys_clk);
        #1 mrst_n = 1'b0;
        #1 chk(32'(pd), 32'hf);
        chk(32'(wflag), 32'h0);
        @(posedge sys_clk);
        #1 mrst_n = 1'b1;
        rb(3, 1'b0, 16'h0000);
        rb(3, 1'b1, 16'hffff);
        end_sim();
    end
endmodule
